// ===== design/line_ctrl_pkg.sv
/*
 * shared constants and types for the uart line, modem control and
 * status block. assumes one clock and a parallel register port fed by
 * the serial host front end.
 */
package line_ctrl_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [2:0] OFS_DATA = 3'h0; // holding regs / divisor low
   localparam logic [2:0] OFS_DIVH = 3'h1; // divisor high when open
   localparam logic [2:0] OFS_EFC = 3'h2; // enhanced control when open
   localparam logic [2:0] OFS_FMT = 3'h3; // character format
   localparam logic [2:0] OFS_MOC = 3'h4; // modem output control
   localparam logic [2:0] OFS_LST = 3'h5; // line status
   localparam logic [2:0] OFS_MIS = 3'h6; // modem status / thresholds
   localparam logic [2:0] OFS_SCR = 3'h7; // scratch / trigger levels
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] FMT_RST = 8'h05; // 6 bits, long stop
   localparam logic [7:0] SCR_RST = 8'hff;
   localparam logic [7:0] DIV_RST = 8'h01;
   localparam logic [7:0] ZERO8 = 8'h00;
   // ****************************************
   // field positions
   // ****************************************
   localparam int FMT_STOP = 2; // long stop
   localparam int FMT_PEN = 3; // parity enable
   localparam int FMT_EVEN = 4; // parity type
   localparam int FMT_FORCE = 5; // forced parity
   localparam int FMT_BRK = 6; // send break
   localparam int FMT_DIV = 7; // divisor access
   localparam int MOC_TRM = 0; // terminal ready
   localparam int MOC_RTS = 1; // request to send
   localparam int MOC_SP1 = 2; // spare one / threshold select
   localparam int MOC_SP2 = 3; // spare two / interrupt enable
   localparam int MOC_LOOP = 4; // internal loopback
   localparam int MOC_XANY = 5; // xon any
   localparam int MOC_IR = 6; // infrared
   localparam int MOC_PRE = 7; // prescaler
   localparam int EFC_ENH = 4; // enhanced functions
   localparam int EFC_SWF = 3; // software flow control
   // ****************************************
   // timing counts in sixteenth bit times, then prescale count and flow characters
   // ****************************************
   localparam logic [5:0] BIT_LAST = 6'h0f; // last tick of a bit
   localparam logic [5:0] MID_TICK = 6'h07; // start bit centre
   localparam logic [5:0] STOP1_LAST = 6'h0f; // one stop bit
   localparam logic [5:0] STOP15_LAST = 6'h17; // one and a half
   localparam logic [5:0] STOP2_LAST = 6'h1f; // two stop bits
   localparam logic [5:0] IR_PULSE = 6'h03; // 3/16 infrared pulse
   localparam logic [1:0] PRE_LAST = 2'h3; // divide by four
   localparam logic [7:0] XON_CHAR = 8'h11;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic brk; // break character
      logic ferr; // framing error
      logic perr; // parity error
      logic [7:0] data;
   } rx_entry_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_START = 3'b001, S_DATA = 3'b010,
      S_PAR = 3'b011, S_STOP = 3'b100, S_HOLD = 3'b101
   } ser_state_t;
endpackage

// ===== design/line_ctrl.sv
/*
 * uart character framing, modem output control and line status, plus
 * the small queue used on both data paths. assumes the serial host
 * front end turns bus cycles into one-cycle read and write strobes.
 */
`timescale 1ns/100ps

// ****************************************
// queue with registered flags
// ****************************************
module byte_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wp; // write pointer
   logic [AW-1:0] rp; // read pointer
   logic [AW:0] count; // fill level
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign o_out_data = mem[rp];
   // pointers and flags; flags kept as flops so ready is clean
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
         if (pop) rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
         count <= next_count;
         o_in_ready <= next_count != (AW+1)'(DEPTH);
         o_out_valid <= next_count != '0;
      end
   end
   // data array, no reset needed
   always_ff @(posedge I_CLK) begin
      if (push) mem[wp] <= i_in_data;
   end
endmodule

// Functional notes
// - low format bits pick 5-8 data bits
// - long stop: 1.5 for 5 bits, else 2
// - parity enable adds and checks parity bit
// - parity type clear odd, set even
// - forced parity is inverse of type bit
// - break bit holds transmit line low
// - divisor access bit redirects shared offsets
// - terminal ready pin is inverse of bit
// - request to send pin inverse of bit
// - spare one feeds ring input in loopback
// - enhanced plus spare one swaps offsets 6/7
// - interrupt enable drives pins, spare two low
// - loopback bit selects internal loopback
// - xon-any, infrared, prescaler need enhanced enable
// - xon-any resumes on any received character except a break or xoff
// - infrared bit enables infrared line encoding
// - prescaler bit divides clock by four
// - data ready while receive queue nonempty
// - overrun when queue full, queue intact
// - parity and framing errors follow head character
// - break after low frame, stored once
// - holding empty follows transmit queue empty
// - transmitter idle needs queue and shifter empty
module line_ctrl
   import line_ctrl_pkg::*;
#(
   parameter int QDEPTH = 4
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic [2:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_txq_ready,
   input wire logic i_rx,
   output logic o_tx,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ri_n,
   input wire logic i_cd_n,
   output logic o_trm_rdy_n,
   output logic o_rts_n,
   output logic o_spare_two_n,
   output logic o_int,
   output logic o_int_oe
);
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] fmt; // character format
   logic [7:0] moc; // modem output control
   logic [7:0] efc; // enhanced feature control
   logic [7:0] divl, divh; // baud divisor
   logic [7:0] scr, thr_lv, trig_lv; // scratch and levels
   logic overrun; // sticky until status read
   logic tx_halted; // software flow halt

   // register selector, used by read and write paths alike
   function automatic logic [3:0] reg_sel(input logic [2:0] a,
      input logic dv, input logic alt);
      logic [3:0] s;
      s = {1'b0, a};
      if (dv && a == OFS_DATA) s = 4'h8;
      if (dv && a == OFS_DIVH) s = 4'h9;
      if (dv && a == OFS_EFC) s = 4'ha;
      if (alt && a == OFS_MIS) s = 4'hb;
      if (alt && a == OFS_SCR) s = 4'hc;
      return s;
   endfunction

   wire enh = efc[EFC_ENH];
   wire loop = moc[MOC_LOOP];
   wire alt_map = enh && moc[MOC_SP1];
   wire [3:0] sel = reg_sel(i_addr, fmt[FMT_DIV], alt_map);
   wire wr_data = i_wr && sel == {1'b0, OFS_DATA};
   wire rd_data = i_rd && sel == {1'b0, OFS_DATA};
   wire rd_lst = i_rd && sel == {1'b0, OFS_LST};

   // ****************************************
   // input synchronisers
   // ****************************************
   // three flops; a change counts once flops two and three agree
   logic [4:0] pin_in;
   wire [4:0] pin_f; // filtered levels, one driver per bit
   assign pin_in = {i_rx, i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         logic s1, s2, s3, f; // local stages keep one process per flop
         always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
               s1 <= 1'b1;
               s2 <= 1'b1;
               s3 <= 1'b1;
               f <= 1'b1;
            end else begin
               s1 <= pin_in[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) f <= s3;
            end
         end
         assign pin_f[g] = f;
      end
   endgenerate

   // ****************************************
   // baud tick: prescaler then divisor
   // ****************************************
   logic [1:0] pre; // divide-by-four counter
   logic [15:0] bcnt; // divisor counter
   wire pre_en = !moc[MOC_PRE] || pre == PRE_LAST;
   wire [15:0] divisor = {divh, divl};
   wire tick = pre_en && (bcnt + 16'h0001 >= divisor);
   // prescale and divide; a zero divisor acts like one
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pre <= '0;
         bcnt <= '0;
      end else begin
         pre <= pre + 2'h1;
         if (tick) bcnt <= '0;
         else if (pre_en) bcnt <= bcnt + 16'h0001;
      end
   end

   // ****************************************
   // format decode
   // ****************************************
   wire [3:0] wlen = 4'h5 + {2'h0, fmt[1:0]};
   wire [5:0] stop_last = !fmt[FMT_STOP] ? STOP1_LAST :
      (fmt[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST;
   // parity bit for a character, data already masked to length
   function automatic logic par_bit(input logic [7:0] d,
      input logic [7:0] f);
      if (f[FMT_FORCE]) return !f[FMT_EVEN];
      return f[FMT_EVEN] ? ^d : !(^d);
   endfunction
   wire [7:0] len_mask = 8'hff >> (4'h8 - wlen);

   // ****************************************
   // transmit path
   // ****************************************
   logic [7:0] txq_data;
   logic txq_valid, txq_pop;
   byte_queue #(.WIDTH(8), .DEPTH(QDEPTH)) u_txq (
      .I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
      .i_in_valid(wr_data), .o_in_ready(o_txq_ready),
      .i_in_data(i_wdata), .o_out_valid(txq_valid),
      .i_out_ready(txq_pop), .o_out_data(txq_data)
   );
   ser_state_t tst; // transmit state
   logic [7:0] tsh; // transmit shifter
   logic [5:0] tcnt; // sixteenths within a bit
   logic [3:0] tbits; // data bits sent
   logic tpar; // parity to send
   logic tx_line; // serial value before pin coding
   assign txq_pop = tst == S_IDLE && txq_valid && !tx_halted;
   wire tbit_end = tick && tcnt == BIT_LAST;
   // transmit sequencer
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tst <= S_IDLE;
         tsh <= ZERO8;
         tcnt <= '0;
         tbits <= '0;
         tpar <= 1'b0;
      end else begin
         if (tick) tcnt <= tcnt + 6'h01;
         case (tst)
            S_IDLE: begin
               tcnt <= '0;
               if (txq_pop) begin
                  tsh <= txq_data & len_mask;
                  tpar <= par_bit(txq_data & len_mask, fmt);
                  tst <= S_START;
               end
            end
            S_START: if (tbit_end) begin
               tcnt <= '0;
               tbits <= '0;
               tst <= S_DATA;
            end
            S_DATA: if (tbit_end) begin
               tcnt <= '0;
               tsh <= tsh >> 1;
               tbits <= tbits + 4'h1;
               if (tbits + 4'h1 == wlen) begin
                  tst <= fmt[FMT_PEN] ? S_PAR : S_STOP;
               end
            end
            S_PAR: if (tbit_end) begin
               tcnt <= '0;
               tst <= S_STOP;
            end
            S_STOP: if (tick && tcnt == stop_last) begin
               tst <= S_IDLE;
            end
            default: tst <= S_IDLE;
         endcase
      end
   end
   // line level from state; break overrides everything
   always_comb begin
      case (tst)
         S_START: tx_line = 1'b0;
         S_DATA: tx_line = tsh[0];
         S_PAR: tx_line = tpar;
         default: tx_line = 1'b1;
      endcase
      if (fmt[FMT_BRK]) tx_line = 1'b0;
   end
   // infrared sends a short high pulse for each zero bit
   wire ir_pulse = !tx_line && tst != S_IDLE && tcnt < IR_PULSE;
   wire tx_pin = loop ? 1'b1 : moc[MOC_IR] ? ir_pulse : tx_line;

   // ****************************************
   // receive path
   // ****************************************
   // loopback feeds the transmit line straight back
   wire rx_in = loop ? tx_line : pin_f[4];
   ser_state_t rst; // receive state
   logic [7:0] rsh; // receive shifter
   logic [5:0] rcnt;
   logic [3:0] rbits;
   logic rpar; // sampled parity bit
   logic rpush; // character complete
   rx_entry_t rent, rq_head;
   logic rq_ready, rq_valid;
   byte_queue #(.WIDTH($bits(rx_entry_t)), .DEPTH(QDEPTH)) u_rxq (
      .I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
      .i_in_valid(rpush), .o_in_ready(rq_ready),
      .i_in_data(rent), .o_out_valid(rq_valid),
      .i_out_ready(rd_data), .o_out_data(rq_head)
   );
   wire rbit_end = tick && rcnt == BIT_LAST;
   wire [7:0] rdata = rsh >> (4'h8 - wlen); // right justify
   wire rbreak = rdata == ZERO8 && !rpar && !rx_in;
   wire is_flow = efc[EFC_SWF] && (rdata == XON_CHAR ||
      rdata == XOFF_CHAR);
   wire rdone = rst == S_STOP && rbit_end;
   assign rent = '{brk: rbreak, ferr: !rx_in,
      perr: fmt[FMT_PEN] && rpar != par_bit(rdata, fmt),
      data: rdata};
   // store unless a flow character is consumed
   assign rpush = rdone && !(is_flow && !rbreak) && rq_ready;
   // receive sequencer
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst <= S_IDLE;
         rsh <= ZERO8;
         rcnt <= '0;
         rbits <= '0;
         rpar <= 1'b0;
      end else begin
         if (tick) rcnt <= rcnt + 6'h01;
         case (rst)
            S_IDLE: begin
               rcnt <= '0;
               if (tick && !rx_in) rst <= S_START;
            end
            S_START: if (tick && rcnt == MID_TICK) begin
               rcnt <= '0;
               rbits <= '0;
               rpar <= 1'b0;
               rst <= rx_in ? S_IDLE : S_DATA; // glitch rejected
            end
            S_DATA: if (rbit_end) begin
               rcnt <= '0;
               rsh <= {rx_in, rsh[7:1]};
               rbits <= rbits + 4'h1;
               if (rbits + 4'h1 == wlen) begin
                  rst <= fmt[FMT_PEN] ? S_PAR : S_STOP;
               end
            end
            S_PAR: if (rbit_end) begin
               rcnt <= '0;
               rpar <= rx_in;
               rst <= S_STOP;
            end
            // a break waits for mark so only one char is stored
            S_STOP: if (rbit_end) rst <= rbreak ? S_HOLD : S_IDLE;
            S_HOLD: if (rx_in) rst <= S_IDLE;
            default: rst <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // register writes and sticky flags
   // ****************************************
   wire [7:0] moc_mask = enh ? 8'hff : 8'h1f;
   // host writes; status offset has no write target
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         fmt <= FMT_RST;
         moc <= ZERO8;
         efc <= ZERO8;
         divl <= DIV_RST;
         divh <= ZERO8;
         scr <= SCR_RST;
         thr_lv <= ZERO8;
         trig_lv <= ZERO8;
      end else if (i_wr) begin
         case (sel)
            {1'b0, OFS_FMT}: fmt <= i_wdata;
            {1'b0, OFS_MOC}: moc <= (i_wdata & moc_mask) |
               (moc & ~moc_mask);
            {1'b0, OFS_SCR}: scr <= i_wdata;
            4'h8: divl <= i_wdata;
            4'h9: divh <= i_wdata;
            4'ha: efc <= i_wdata;
            4'hb: thr_lv <= i_wdata;
            4'hc: trig_lv <= i_wdata;
            default: ; // data, status, modem status and offsets 1 and 2 with divisor access closed
         endcase
      end
   end
   // overrun and flow halt; a new event wins over the clear
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         overrun <= 1'b0;
         tx_halted <= 1'b0;
      end else begin
         if (rdone && !rq_ready) overrun <= 1'b1;
         else if (rd_lst) overrun <= 1'b0;
         if (rdone && !rbreak) begin
            if (is_flow && rdata == XOFF_CHAR) tx_halted <= 1'b1;
            else if (is_flow || moc[MOC_XANY]) tx_halted <= 1'b0;
         end
      end
   end

   // ****************************************
   // status and read data
   // ****************************************
   wire tx_idle = !txq_valid && tst == S_IDLE;
   wire [7:0] lst = {1'b0, tx_idle, !txq_valid,
      rq_valid && rq_head.brk, rq_valid && rq_head.ferr,
      rq_valid && rq_head.perr, overrun, rq_valid};
   // loopback mirrors the output bits; spare one drives ring
   wire [3:0] mst = loop ? {moc[MOC_SP2], moc[MOC_SP1],
      moc[MOC_TRM], moc[MOC_RTS]} : ~pin_f[3:0];
   logic [7:0] rd_mux;
   // read selection
   always_comb begin
      case (sel)
         {1'b0, OFS_DATA}: rd_mux = rq_head.data;
         {1'b0, OFS_FMT}: rd_mux = fmt;
         {1'b0, OFS_MOC}: rd_mux = moc;
         {1'b0, OFS_LST}: rd_mux = lst;
         {1'b0, OFS_MIS}: rd_mux = {mst, 4'h0};
         {1'b0, OFS_SCR}: rd_mux = scr;
         4'h8: rd_mux = divl;
         4'h9: rd_mux = divh;
         4'ha: rd_mux = efc;
         4'hb: rd_mux = thr_lv;
         4'hc: rd_mux = trig_lv;
         default: rd_mux = ZERO8;
      endcase
   end

   // ****************************************
   // registered outputs
   // ****************************************
   // modem pins idle high in loopback, as nothing leaves the chip
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         o_rdata <= ZERO8;
         o_tx <= 1'b1;
         o_trm_rdy_n <= 1'b1;
         o_rts_n <= 1'b1;
         o_spare_two_n <= 1'b1;
         o_int <= 1'b0;
         o_int_oe <= 1'b0;
      end else begin
         if (i_rd) o_rdata <= rd_mux;
         o_tx <= tx_pin;
         o_trm_rdy_n <= loop || !moc[MOC_TRM];
         o_rts_n <= loop || !moc[MOC_RTS];
         o_spare_two_n <= loop || !moc[MOC_SP2];
         o_int <= rq_valid || !txq_valid;
         o_int_oe <= moc[MOC_SP2];
      end
   end
endmodule

// ===== verification/line_ctrl_assertions.sv
/* checker for the line control block ports.
   assumes a bind onto line_ctrl with one clock. */
`timescale 1ns/100ps
// ********
// checker
// ********
module line_ctrl_chk
   import line_ctrl_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic [2:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic o_tx,
   input wire logic o_trm_rdy_n,
   input wire logic o_rts_n,
   input wire logic o_spare_two_n,
   input wire logic o_int_oe
);
   logic [7:0] fmt_q; // shadow of format reg
   logic [4:0] moc_q; // shadow of ungated modem bits
   logic [4:0] moc_p; // the same, one cycle late
   wire wr_fmt = i_wr && i_addr == OFS_FMT; // format write
   wire wr_moc = i_wr && i_addr == OFS_MOC; // modem write
   wire settled = moc_q == moc_p; // outputs had a cycle
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   // shadows; top modem bits are gated, so not kept
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         fmt_q <= FMT_RST;
         moc_q <= '0;
         moc_p <= '0;
      end else begin
         if (wr_fmt) fmt_q <= i_wdata;
         if (wr_moc) moc_q <= i_wdata[4:0];
         moc_p <= moc_q;
      end
   end
   sequence s_scr_wr;
      i_wr && i_addr == OFS_SCR && !moc_q[MOC_SP1];
   endsequence
   sequence s_scr_rd;
      i_rd && i_addr == OFS_SCR;
   endsequence
   property p_scr;
      s_scr_wr ##1 s_scr_rd |=> o_rdata == $past(i_wdata, 2);
   endproperty
   property p_hold;
      !i_rd |=> $stable(o_rdata);
   endproperty
   property p_brk;
      fmt_q[FMT_BRK] [*2] |-> !o_tx;
   endproperty
   property p_bit;
      $fell(o_tx) |-> !o_tx [*8];
   endproperty
   property p_trm;
      settled |-> o_trm_rdy_n == (moc_q[MOC_LOOP] | !moc_q[MOC_TRM]);
   endproperty
   property p_rts;
      settled |-> o_rts_n == (moc_q[MOC_LOOP] | !moc_q[MOC_RTS]);
   endproperty
   property p_sp2;
      settled |-> o_spare_two_n == (moc_q[MOC_LOOP] | !moc_q[MOC_SP2]);
   endproperty
   property p_ioe;
      $rose(moc_q[MOC_SP2]) |=> o_int_oe;
   endproperty
   a_scr: assert property (p_scr) else $error("scratch readback wrong");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_brk: assert property (p_brk) else $error("break not low");
   a_bit: assert property (p_bit) else $error("low bit too short");
   a_trm: assert property (p_trm) else $error("terminal ready wrong");
   a_rts: assert property (p_rts) else $error("request to send wrong");
   a_sp2: assert property (p_sp2) else $error("spare two wrong");
   a_ioe: assert property (p_ioe) else $error("int enable late");
endmodule
bind line_ctrl line_ctrl_chk u_chk (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
   .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_tx(o_tx), .o_trm_rdy_n(o_trm_rdy_n), .o_rts_n(o_rts_n),
   .o_spare_two_n(o_spare_two_n), .o_int_oe(o_int_oe));

// ===== verification/serial_peer.sv
/* remote serial device model on the line.
   assumes the bench sets bit period and frame size. */
`timescale 1ns/100ps
// ********
// peer
// ********
module serial_peer (
   input wire logic clk,
   input wire logic tx,
   output logic rx,
   output logic [10:0] frame,
   output logic got
);
   int per = 16; // clocks per bit
   int nb = 9; // bits sampled after start
   bit listen = 1'b1; // off while line is held low on purpose
   initial begin
      rx = 1'b1;
      got = 1'b0;
      frame = '0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk) #1;
   endtask
   // mid-bit sampling, lsb first
   always @(negedge tx) begin
      if (listen) begin
         frame = '0;
         tk(per / 2);
         for (int i = 0; i < nb; i++) begin
            tk(per);
            frame[i] = tx;
         end
         got = 1'b1;
         tk(1);
         got = 1'b0;
      end
   end
   // start bit, n bits lsb first, idle high after
   task send(input logic [23:0] w, input int n);
      rx = 1'b0;
      tk(per);
      for (int i = 0; i < n; i++) begin
         rx = w[i];
         tk(per);
      end
      rx = 1'b1;
      tk(per);
   endtask
endmodule

// ===== verification/uart_line_modem_control_status_tb_top.sv
/* bench for the line control block.
   assumes divisor one: sixteen clocks per bit. */
`timescale 1ns/100ps
module uart_line_modem_control_status_tb_top
   import line_ctrl_pkg::*;
;
   logic I_CLK = 1'b0;
   logic I_ARST_N;
   logic [2:0] i_addr;
   logic i_wr, i_rd, i_rx, o_tx, o_txq_ready;
   logic [7:0] i_wdata, o_rdata;
   logic o_trm_rdy_n, o_rts_n, o_spare_two_n, o_int, o_int_oe;
   logic [10:0] frame;
   logic got;
   int bad_count = 0, n_checks = 0, seed = 8874;
   logic [10:0] fq[$]; // frames still owed
   logic [7:0] rq[$]; // read data still owed
   logic [7:0] v[5];
   always #20 I_CLK = ~I_CLK;
   line_ctrl #(.QDEPTH(4)) DUT (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .i_addr(i_addr),
      .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .o_txq_ready(o_txq_ready), .i_rx(i_rx), .o_tx(o_tx), .i_cts_n(1'b1),
      .i_dsr_n(1'b1), .i_ri_n(1'b1), .i_cd_n(1'b1), .o_trm_rdy_n(o_trm_rdy_n),
      .o_rts_n(o_rts_n), .o_spare_two_n(o_spare_two_n), .o_int(o_int),
      .o_int_oe(o_int_oe));
   serial_peer peer (.clk(I_CLK), .tx(o_tx), .rx(i_rx), .frame(frame), .got(got));
   // ********
   // tasks
   // ********
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [10:0] g, input logic [10:0] e);
      n_checks++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask
   // strobes drop here, so back-to-back calls never touch one twice
   task cyc(input int n);
      if (i_wr) i_wr = 1'b0;
      if (i_rd) i_rd = 1'b0;
      repeat (n) @(posedge I_CLK) #1;
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      i_addr = a;
      i_wdata = d;
      i_rd = 1'b0;
      i_wr = 1'b1;
      @(posedge I_CLK) #1;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      i_addr = a;
      i_wr = 1'b0;
      i_rd = 1'b1;
      rq.push_back(e);
      @(posedge I_CLK) #1;
   endtask
   // bounded wait until the peer took every owed frame
   task fwait;
      for (int k = 0; k < 4000 && fq.size() > 0; k++) cyc(1);
      if (fq.size() > 0) begin
         bad_count++;
         end_of_test;
      end
      cyc(200);
   endtask
   // sends one byte; expected frame: data, parity, first stop
   task tx1(input logic [7:0] f, input logic [7:0] d);
      int wl;
      logic [10:0] w;
      wl = f[1:0] + 5;
      d = d & (8'hff >> (8 - wl));
      w = {3'h0, d};
      w[wl] = f[5] ? !f[4] : (f[4] ? ^d : ~^d);
      w[wl + f[3]] = 1'b1;
      peer.nb = wl + f[3] + 1;
      wr(OFS_FMT, f);
      fq.push_back(w);
      wr(OFS_DATA, d);
      fwait;
   endtask
   // ********
   // watchers
   // ********
   always @(posedge I_CLK) begin
      if (i_rd) begin
         #2;
         chk({3'h0, o_rdata}, {3'h0, rq.pop_front()});
      end
   end
   always @(posedge got) chk(frame, fq.size() > 0 ? fq.pop_front() : 'x);
   // ********
   // sequence
   // ********
   initial begin
      I_ARST_N = 1'b0;
      i_addr = '0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_wdata = '0;
      cyc(2);
      I_ARST_N = 1'b1;
      cyc(1);
      chk({6'h0, o_tx, o_trm_rdy_n, o_rts_n, o_spare_two_n, o_int_oe}, 11'h1e);
      rd(OFS_FMT, FMT_RST);
      rd(OFS_MOC, ZERO8);
      rd(OFS_SCR, SCR_RST);
      wr(OFS_SCR, 8'h3c);
      rd(OFS_SCR, 8'h3c);
      wr(OFS_LST, 8'h1f);
      rd(OFS_LST, 8'h60);
      for (int k = 0; k < 8; k++) tx1({2'h0, 3'(k), 1'b0, 2'(k)}, 8'($random(seed)));
      tx1(8'h07, 8'($random(seed)));
      wr(OFS_FMT, 8'h83);
      wr(OFS_DATA, 8'h02);
      rd(OFS_DATA, 8'h02);
      peer.per = 32;
      tx1(8'h03, 8'($random(seed)));
      wr(OFS_MOC, 8'he0);
      rd(OFS_MOC, ZERO8);
      wr(OFS_FMT, 8'h83);
      wr(OFS_DATA, 8'h01);
      wr(OFS_EFC, 8'h10);
      wr(OFS_FMT, 8'h03);
      wr(OFS_MOC, 8'h84);
      rd(OFS_MOC, 8'h84);
      wr(OFS_SCR, 8'h5a);
      rd(OFS_SCR, 8'h5a);
      wr(OFS_MIS, 8'hc3);
      rd(OFS_MIS, 8'hc3);
      peer.per = 64;
      tx1(8'h03, 8'($random(seed)));
      peer.per = 16;
      wr(OFS_MOC, ZERO8);
      rd(OFS_SCR, 8'h3c);
      rd(OFS_MIS, ZERO8);
      peer.listen = 1'b0;
      wr(OFS_FMT, 8'h43);
      cyc(20);
      chk({8'h0, o_txq_ready, o_int, o_tx}, 11'h6);
      wr(OFS_FMT, 8'h03);
      cyc(2);
      chk({10'h0, o_tx}, 11'h1);
      for (int m = 0; m < 32; m++) begin
         wr(OFS_MOC, 8'(m));
         cyc(1);
         chk({7'h0, o_trm_rdy_n, o_rts_n, o_spare_two_n, o_int_oe},
            {7'h0, m[4] | !m[0], m[4] | !m[1], m[4] | !m[3], m[3] == 1'b1});
      end
      wr(OFS_FMT, 8'h83);
      wr(OFS_EFC, ZERO8);
      wr(OFS_FMT, 8'h03);
      wr(OFS_MOC, 8'h14);
      rd(OFS_MIS, 8'h40);
      v[0] = 8'($random(seed));
      wr(OFS_MOC, 8'h10);
      wr(OFS_DATA, v[0]);
      cyc(250);
      rd(OFS_DATA, v[0]);
      wr(OFS_MOC, ZERO8);
      cyc(2);
      peer.listen = 1'b1;
      foreach (v[j]) v[j] = 8'($random(seed));
      foreach (v[j]) peer.send({1'b1, v[j]}, 9);
      rd(OFS_LST, 8'h63);
      for (int j = 0; j < 4; j++) rd(OFS_DATA, v[j]);
      rd(OFS_LST, 8'h60);
      wr(OFS_FMT, 8'h1b);
      cyc(1);
      peer.send({1'b1, ~^v[0], v[0]}, 10);
      rd(OFS_LST, 8'h65);
      rd(OFS_DATA, v[0]);
      cyc(1);
      peer.send({1'b0, ^v[1], v[1]}, 10);
      rd(OFS_LST, 8'h69);
      rd(OFS_DATA, v[1]);
      cyc(1);
      peer.send(24'h0, 24);
      rd(OFS_LST, 8'h79);
      rd(OFS_DATA, ZERO8);
      rd(OFS_LST, 8'h60);
      cyc(4);
      end_of_test;
   end
endmodule
